// ===== csio_pkg.sv
// Package: register map, field positions, reset values and mode codes
package csio_pkg;
  // Avalon word addresses (byte offset = 4 * index)
  localparam logic [2:0] ADDR_MODE    = 3'h0; // serial_mode_reg
  localparam logic [2:0] ADDR_DIVIDER = 3'h1; // bit_rate_divider
  localparam logic [2:0] ADDR_TXBUF   = 3'h2; // transmit_buffer
  localparam logic [2:0] ADDR_CTRL0   = 3'h4; // serial_control_0
  localparam logic [2:0] ADDR_CTRL1   = 3'h5; // serial_control_1
  localparam logic [2:0] ADDR_RXBUF   = 3'h6; // receive_buffer (16 bit)
  // serial_mode_reg fields
  localparam int MODE_FIELD_LSB = 0;
  localparam int EXT_CLK_BIT    = 3;
  localparam logic [2:0] MODE_DISABLED = 3'h0;
  localparam logic [2:0] MODE_CLOCKSYNC = 3'h1;
  // serial_control_0 fields
  localparam int SRC_SEL_LSB  = 0;
  localparam int SHIFT_EMPTY_BIT = 3;
  localparam int OPEN_DRAIN_BIT = 5;
  localparam int POLARITY_BIT = 6;
  localparam int BIT_ORDER_BIT = 7;
  // serial_control_1 fields
  localparam int TX_EN_BIT      = 0;
  localparam int TX_EMPTY_BIT   = 1;
  localparam int RX_EN_BIT      = 2;
  localparam int RX_DONE_BIT    = 3;
  localparam int IRQ_SRC_BIT    = 4;
  localparam int CONT_RX_BIT    = 5;
  localparam int OVERRUN_BIT    = 12;
  // Reset values
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h02;
  localparam logic [7:0] DIV_RESET   = 8'h00;
  // Count source prescale ratios, frame and overrun bit counts
  localparam int PRE_F8  = 8;
  localparam int PRE_F32 = 32;
  localparam int PRE_FC  = 4;
  localparam int FRAME_BITS = 8;
  localparam int OVERRUN_BIT_COUNT = 7;
endpackage : csio_pkg

// ===== csio_rate_gen.sv
// Count source prescaler and bit-rate divider producing half-period ticks
`timescale 1ns/1ps
`default_nettype none
module csio_rate_gen
  import csio_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] source_sel,
  input  wire logic [7:0] divider,
  output logic            half_tick
);
  logic [4:0] pre_cnt;
  logic [4:0] next_pre_cnt;
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic       src_en;
  logic       next_half_tick;

  // Prescaler: f1, f8, f32 or fC (fC modelled as a fixed divide)
  always_comb begin
    logic [4:0] last;
    last = 5'h0;
    unique case (source_sel)
      2'b00: last = 5'h0;
      2'b01: last = 5'(PRE_F8 - 1);
      2'b10: last = 5'(PRE_F32 - 1);
      2'b11: last = 5'(PRE_FC - 1);
    endcase
    src_en = run && (pre_cnt == last);
    next_pre_cnt = (!run || src_en) ? 5'h0 : pre_cnt + 5'h1;
    // Divide by n+1 per half period gives fi/(2(n+1))
    next_div_cnt = div_cnt;
    next_half_tick = 1'b0;
    if (!run) begin
      next_div_cnt = 8'h00;
    end else if (src_en) begin
      if (div_cnt == divider) begin
        next_div_cnt = 8'h00;
        next_half_tick = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end
  end

  // Register the counters
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt <= 5'h0;
      div_cnt <= 8'h00;
      half_tick <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      half_tick <= next_half_tick;
    end
  end
endmodule : csio_rate_gen
`default_nettype wire

// ===== csio_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module csio_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  input  wire logic reset_level,
  output logic      sync_out
);
  logic meta;
  // Only the second stage is read by logic; reset to high keeps idle lines quiet
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= reset_level;
      sync_out <= reset_level;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : csio_sync
`default_nettype wire

// ===== csio_core.sv
// Clock-synchronous serial unit: Avalon registers, shifter and clock logic
//
// Functional notes
// - Frames are exactly eight data bits
// - Internal clock is fi divided by 2(n+1)
// - External clock pin drives shifting when selected
// - Transmit starts on enable and buffer full
// - Receive also needs transmit enable and data
// - Transmit event on load or on completion
// - Receive event when frame enters buffer
// - Overrun when seventh bit of unread frame
// - Overrun leaves data undefined, event untouched
// - Polarity swaps output and sample edges
// - Bit order selects LSB or MSB first
// - Mode field 001b selects this operation
// - Output idles high, or released if open-drain
// - Continuous receive: buffer read refills transmit flag
// - Transmit recovery honours enable rewrite
// - Reading receive upper byte clears complete
// - Errors clear on mode off or receive off
// - Shift-empty flag reads one when idle
// - Two-bit select picks f1, f8, f32, fC
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module csio_core
  import csio_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        serial_data_in_pin,
  output logic             serial_data_out_o,
  output logic             serial_data_out_oe,
  input  wire logic        clock_pin_i,
  output logic             clock_pin_o,
  output logic             clock_pin_oe,
  output logic             tx_irq_pulse,
  output logic             rx_irq_pulse
);
  typedef enum logic [1:0] {IDLE, SHIFT, FINISH} state_e;

  // Registers
  logic [7:0] serial_mode_reg, bit_rate_divider, transmit_buffer;
  logic [7:0] serial_control_0, serial_control_1, receive_buffer;
  logic       overrun_flag;
  logic       ack;
  state_e     state;
  logic [7:0] tx_shift, rx_shift;
  logic [3:0] bit_cnt;
  logic       clk_level, data_out;
  logic       ext_prev;
  // Next values
  logic [7:0] next_mode, next_div, next_txbuf, next_ctrl0, next_ctrl1, next_rxbuf;
  logic       next_overrun, next_ack;
  state_e     next_state;
  logic [7:0] next_tx_shift, next_rx_shift;
  logic [3:0] next_bit_cnt;
  logic       next_clk_level, next_data_out, next_ext_prev;
  logic       next_tx_irq, next_rx_irq;

  logic rx_sync, ext_sync, half_tick;
  logic mode_on, ext_clk, polarity, msb_first, idle_level;
  logic tx_en, tx_empty, rx_en, rx_done, cont_rx;
  logic wr_hit, rd_hit;

  // Pin inputs pass two flops before use
  csio_sync u_rx_sync (
    .clk         (clk),
    .rst         (rst),
    .async_in    (serial_data_in_pin),
    .reset_level (1'b1),
    .sync_out    (rx_sync)
  );
  csio_sync u_ck_sync (
    .clk         (clk),
    .rst         (rst),
    .async_in    (clock_pin_i),
    .reset_level (1'b1),
    .sync_out    (ext_sync)
  );

  // Divider runs only while a frame shifts on the internal clock
  csio_rate_gen u_rate (
    .clk        (clk),
    .rst        (rst),
    .run        (state == SHIFT && !ext_clk),
    .source_sel (serial_control_0[SRC_SEL_LSB +: 2]),
    .divider    (bit_rate_divider),
    .half_tick  (half_tick)
  );

  // Field decode
  assign mode_on   = serial_mode_reg[MODE_FIELD_LSB +: 3] == MODE_CLOCKSYNC;
  assign ext_clk   = serial_mode_reg[EXT_CLK_BIT];
  assign polarity  = serial_control_0[POLARITY_BIT];
  assign msb_first = serial_control_0[BIT_ORDER_BIT];
  assign idle_level = ~polarity;   // Idle high for polarity 0, low for 1
  assign tx_en     = serial_control_1[TX_EN_BIT];
  assign tx_empty  = serial_control_1[TX_EMPTY_BIT];
  assign rx_en     = serial_control_1[RX_EN_BIT];
  assign rx_done   = serial_control_1[RX_DONE_BIT];
  assign cont_rx   = serial_control_1[CONT_RX_BIT];
  // One wait cycle: writes land on the edge where waitrequest is low; reads
  // load their data one edge early so it already stands at that edge
  assign wr_hit = avs_write && ack;
  assign rd_hit = avs_read && !ack;
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  // Pin drive: clock only when internal, data idles high or released
  assign clock_pin_o  = clk_level;
  assign clock_pin_oe = mode_on && !ext_clk;
  assign serial_data_out_o  = data_out;
  assign serial_data_out_oe = mode_on && !(serial_control_0[OPEN_DRAIN_BIT] && data_out);

  // Register file, shifter and flags in one next-state block
  always_comb begin
    logic lead, trail, sample_bit, edge_seen, ck_now;
    next_mode = serial_mode_reg;
    next_div = bit_rate_divider;
    next_txbuf = transmit_buffer;
    next_ctrl0 = serial_control_0;
    next_ctrl1 = serial_control_1;
    next_rxbuf = receive_buffer;
    next_overrun = overrun_flag;
    next_ack = (avs_read || avs_write) && !ack;
    next_state = state;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_bit_cnt = bit_cnt;
    next_clk_level = clk_level;
    next_data_out = data_out;
    next_ext_prev = ext_sync;
    next_tx_irq = 1'b0;
    next_rx_irq = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    edge_seen = 1'b0;
    ck_now = 1'b0;
    sample_bit = rx_sync;
    // Edge source: external pin or internal toggle
    if (ext_clk) begin
      edge_seen = ext_sync != ext_prev;
      ck_now = ext_sync;
    end else begin
      edge_seen = half_tick;
      ck_now = ~clk_level;
      if (half_tick) begin
        next_clk_level = ~clk_level;
      end
    end
    // Leading edge moves away from idle: output; trailing returns: sample
    if (state == SHIFT && edge_seen) begin
      lead = (ck_now != idle_level);
      trail = (ck_now == idle_level);
    end

    // Bus writes
    if (wr_hit && avs_byteenable[0]) begin
      unique case (avs_address)
        ADDR_MODE: begin
          next_mode = avs_writedata[7:0];
        end
        ADDR_DIVIDER: begin
          next_div = avs_writedata[7:0];
        end
        ADDR_TXBUF: begin
          next_txbuf = avs_writedata[7:0];
          next_ctrl1[TX_EMPTY_BIT] = 1'b0;
        end
        ADDR_CTRL0: begin
          next_ctrl0[7:5] = avs_writedata[7:5];
          next_ctrl0[1:0] = avs_writedata[1:0];
        end
        ADDR_CTRL1: begin
          next_ctrl1[TX_EN_BIT] = avs_writedata[TX_EN_BIT];
          next_ctrl1[RX_EN_BIT] = avs_writedata[RX_EN_BIT];
          next_ctrl1[IRQ_SRC_BIT] = avs_writedata[IRQ_SRC_BIT];
          next_ctrl1[CONT_RX_BIT] = avs_writedata[CONT_RX_BIT];
        end
        default: begin
        end
      endcase
    end
    // Reading upper byte clears complete; continuous mode refills
    if (rd_hit && avs_address == ADDR_RXBUF && avs_byteenable[1]) begin
      next_ctrl1[RX_DONE_BIT] = 1'b0;
      if (cont_rx) begin
        next_ctrl1[TX_EMPTY_BIT] = 1'b0;
      end
    end

    // Frame engine
    unique case (state)
      IDLE: begin
        next_clk_level = idle_level;   // No pulses between frames
        next_data_out = 1'b1;          // Idle high until transfer
        if (mode_on && tx_en && !tx_empty) begin
          next_tx_shift = transmit_buffer;
          next_ctrl1[TX_EMPTY_BIT] = 1'b1;
          next_bit_cnt = 4'h0;
          next_state = SHIFT;
          next_tx_irq = !serial_control_1[IRQ_SRC_BIT];
        end
      end
      SHIFT: begin
        if (lead) begin
          next_data_out = msb_first ? tx_shift[7] : tx_shift[0];
          next_tx_shift = msb_first ? {tx_shift[6:0], 1'b0} : {1'b0, tx_shift[7:1]};
        end
        if (trail) begin
          next_rx_shift = msb_first ? {rx_shift[6:0], sample_bit}
                                    : {sample_bit, rx_shift[7:1]};
          next_bit_cnt = bit_cnt + 4'h1;
          // Seventh bit of a frame while the buffer is unread
          if (rx_en && rx_done && bit_cnt == 4'(OVERRUN_BIT_COUNT - 1)) begin
            next_overrun = 1'b1;
          end
          if (bit_cnt == 4'(FRAME_BITS - 1)) begin
            next_state = FINISH;
          end
        end
      end
      FINISH: begin
        next_state = IDLE;
        next_data_out = 1'b1;
        next_tx_irq = serial_control_1[IRQ_SRC_BIT];
        if (rx_en) begin
          // Buffer overwritten; an overrun frame leaves the event alone
          next_rxbuf = rx_shift;
          next_ctrl1[RX_DONE_BIT] = 1'b1;
          next_rx_irq = !(overrun_flag && rx_done);
        end
      end
    endcase

    // Mode off clears errors and aborts; receive off only clears errors
    if (!mode_on) begin
      next_state = IDLE;
      next_ctrl1[TX_EMPTY_BIT] = 1'b1;
      next_overrun = 1'b0;
    end
    if (!next_ctrl1[RX_EN_BIT]) begin
      next_overrun = 1'b0;
    end
  end

  // Shift-empty status reflects engine state
  logic [7:0] ctrl0_view;
  assign ctrl0_view = {serial_control_0[7:5], 1'b0, (state == IDLE), 1'b0,
                       serial_control_0[1:0]};

  // Read data is captured in the wait cycle so it stands at the accepting edge
  logic [31:0] next_readdata;
  always_comb begin
    next_readdata = avs_readdata;
    if (rd_hit) begin
      unique case (avs_address)
        ADDR_MODE:    next_readdata = {24'h00_0000, serial_mode_reg};
        ADDR_DIVIDER: next_readdata = {24'h00_0000, bit_rate_divider};
        ADDR_TXBUF:   next_readdata = {24'h00_0000, transmit_buffer};
        ADDR_CTRL0:   next_readdata = {24'h00_0000, ctrl0_view};
        ADDR_CTRL1:   next_readdata = {24'h00_0000, serial_control_1};
        ADDR_RXBUF:   next_readdata = {19'h0_0000, overrun_flag, 4'h0, receive_buffer};
        default:      next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_mode_reg <= MODE_RESET;
      bit_rate_divider <= DIV_RESET;
      transmit_buffer <= 8'h00;
      serial_control_0 <= CTRL0_RESET;
      serial_control_1 <= CTRL1_RESET;
      receive_buffer <= 8'h00;
      overrun_flag <= 1'b0;
      ack <= 1'b0;
      state <= IDLE;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      bit_cnt <= 4'h0;
      clk_level <= 1'b1;
      data_out <= 1'b1;
      ext_prev <= 1'b1;
      tx_irq_pulse <= 1'b0;
      rx_irq_pulse <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      serial_mode_reg <= next_mode;
      bit_rate_divider <= next_div;
      transmit_buffer <= next_txbuf;
      serial_control_0 <= next_ctrl0;
      serial_control_1 <= next_ctrl1;
      receive_buffer <= next_rxbuf;
      overrun_flag <= next_overrun;
      ack <= next_ack;
      state <= next_state;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      bit_cnt <= next_bit_cnt;
      clk_level <= next_clk_level;
      data_out <= next_data_out;
      ext_prev <= next_ext_prev;
      tx_irq_pulse <= next_tx_irq;
      rx_irq_pulse <= next_rx_irq;
      avs_readdata <= next_readdata;
    end
  end
endmodule : csio_core
`default_nettype wire

// ===== csio_props.sv
// Port checker for the serial unit, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module csio_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        serial_data_out_o,
  input wire logic        clock_pin_oe,
  input wire logic        tx_irq_pulse,
  input wire logic        rx_irq_pulse
);
  wire req = avs_read | avs_write; // Any pending bus request
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bus handshake: exactly one wait cycle, then the answer
  a_answer_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_first_wait: assert property (req && !avs_waitrequest |-> $past(avs_waitrequest))
    else $error("bus answer without wait cycle");
  a_idle_wait: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised without request");
  // Read data only moves after a read was presented
  a_rd_stable: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  // Events are single pulses at least nine cycles apart
  a_tx_spacing: assert property (tx_irq_pulse |=> !tx_irq_pulse [*8])
    else $error("transmit event too close");
  a_rx_spacing: assert property (rx_irq_pulse |=> !rx_irq_pulse [*8])
    else $error("receive event too close");
  // Quiet outputs straight after reset
  a_reset_idle: assert property ($fell(rst) |-> serial_data_out_o && !clock_pin_oe
    && !tx_irq_pulse && !rx_irq_pulse && avs_readdata == 32'h0000_0000)
    else $error("outputs not idle after reset");
endmodule : csio_props
bind csio_core csio_props u_props (.clk(clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .serial_data_out_o(serial_data_out_o), .clock_pin_oe(clock_pin_oe),
  .tx_irq_pulse(tx_irq_pulse), .rx_irq_pulse(rx_irq_pulse));
`default_nettype wire

// ===== csio_peer.sv
// Behavioural serial peer: optional clock source, data source and sink
`timescale 1ns/1ps
`default_nettype none
module csio_peer (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       ext,
  input  wire logic       pol,
  input  wire logic       msb,
  input  wire logic [7:0] half,
  input  wire logic [7:0] tx_byte,
  input  wire logic       sclk,
  input  wire logic       sdo,
  output logic            sclk_out,
  output logic            sdi,
  output logic [7:0]      cap,
  output logic [4:0]      edges
);
  logic       prev = 1'b1;
  logic [3:0] lead = 4'h0;
  logic [3:0] age  = 4'h0;
  initial sdi = 1'b0;
  initial cap = 8'h00;
  initial edges = 5'h00;
  // Data moves on the edge away from idle and is taken on the return edge
  always @(posedge clk) begin
    prev <= sclk;
    age  <= (sclk != prev) ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    if (go) begin
      edges <= 5'h00;
      lead  <= 4'h0;
    end else if (sclk != prev && sclk == pol) begin
      sdi   <= msb ? tx_byte[3'd7 - lead[2:0]] : tx_byte[lead[2:0]];
      lead  <= lead + 4'h1;
      edges <= edges + 5'h01;
    end else if (sclk != prev) begin
      cap   <= msb ? {cap[6:0], sdo} : {sdo, cap[7:1]};
      edges <= edges + 5'h01;
    end else if (!edges[0] && age > 4'h4) begin
      sdi <= ~sdi; // Stale between bits so a late sample is caught
    end
  end
  // External clock: idle level from polarity, eight pulses after a go
  initial begin
    sclk_out = 1'b1;
    forever begin
      @(posedge clk);
      if (go && ext) begin
        repeat (32) @(posedge clk);
        repeat (16) begin
          repeat (half) @(posedge clk);
          sclk_out <= ~sclk_out;
        end
      end else begin
        sclk_out <= ~pol;
      end
    end
  end
endmodule : csio_peer
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench: registers, start rules, frames, overrun, recovery
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import csio_pkg::*;
();
  logic        clk, rst, rd, wr, go, ext, pol, msb, unread, prev_ck;
  logic        wreq, sdo_o, sdo_oe, ck_o, ck_oe, txi, rxi, psck, psdi;
  logic [2:0]  adr;
  logic [31:0] wdat, rdat, got;
  logic [7:0]  half, pbyte, pcap, rnd;
  logic [4:0]  pedges;
  int          seed, err_count, checked, cyc, tog, last, gmin, gmax, ntx, nrx, txat;
  logic [2:0]  ra [6] = '{ADDR_MODE, ADDR_DIVIDER, ADDR_CTRL0, ADDR_CTRL1, 3'h3, 3'h7};
  logic [7:0]  rv [6] = '{MODE_RESET, DIV_RESET, 8'h08, CTRL1_RESET, 8'h00, 8'h00};
  wire         sclk = ck_oe ? ck_o : psck;
  wire         sdo  = sdo_oe ? sdo_o : 1'b1; // Pull-up holds a released line high
  csio_core uut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .serial_data_in_pin(psdi), .serial_data_out_o(sdo_o),
    .serial_data_out_oe(sdo_oe), .clock_pin_i(psck), .clock_pin_o(ck_o),
    .clock_pin_oe(ck_oe), .tx_irq_pulse(txi), .rx_irq_pulse(rxi));
  csio_peer peer (.clk(clk), .go(go), .ext(ext), .pol(pol), .msb(msb), .half(half),
    .tx_byte(pbyte), .sclk(sclk), .sdo(sdo), .sclk_out(psck), .sdi(psdi), .cap(pcap),
    .edges(pedges));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  // Avalon access held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    rd   <= !w;
    wr   <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic clr();
    tog  = 0;
    gmin = 9999;
    gmax = 0;
    ntx  = 0;
    nrx  = 0;
  endtask : clr
  // One frame: configure, start, wait for 16 wire edges, compare both directions
  task automatic frame(input logic e, p, m, irs, r, c, rdx, input logic [1:0] s,
                       input logic [7:0] n);
    int         h;
    logic [7:0] b;
    logic       ov;
    b  = $random(seed);
    h  = (s == 2'd0 ? 1 : s == 2'd1 ? PRE_F8 : s == 2'd2 ? PRE_F32 : PRE_FC) * (n + 1);
    ov = unread;
    pol   <= p;
    msb   <= m;
    ext   <= e;
    half  <= 8'd10;
    pbyte <= $random(seed);
    bus(1, ADDR_CTRL0, {m, p, 4'h0, s});
    bus(1, ADDR_DIVIDER, n);
    bus(1, ADDR_MODE, {e, MODE_CLOCKSYNC});
    bus(1, ADDR_CTRL1, {c, irs, 1'b0, r, 2'b01});
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    clr();
    bus(1, ADDR_TXBUF, b);
    while (pedges < 16) @(posedge clk);
    repeat (12) @(posedge clk);
    check("peer byte", pcap, b);
    check("tx events", ntx, 1);
    check("tx moment", txat, irs ? 16 : 0);
    check("clock edges", tog, e ? 0 : 16);
    if (!e) check("half min", gmin, h);
    if (!e) check("half max", gmax, h);
    check("idle clock", sclk, !p);
    check("idle data", sdo, 1'b1);
    check("rx events", nrx, ov ? 1'b0 : r);
    bus(0, ADDR_CTRL0, 0);
    check("shift empty", got[SHIFT_EMPTY_BIT], 1'b1);
    bus(0, ADDR_CTRL1, 0);
    check("rx complete", got[RX_DONE_BIT], r);
    unread = r && !rdx;
    if (r && rdx) begin
      bus(0, ADDR_RXBUF, 0);
      check("overrun", got[OVERRUN_BIT], ov);
      if (!ov) check("rx byte", got[7:0], pbyte);
      bus(0, ADDR_CTRL1, 0);
      check("rx cleared", got[RX_DONE_BIT], 1'b0);
    end
    if (c) begin
      // No transmit write here: the buffer read alone restarts the link
      repeat (20 * h + 40) @(posedge clk);
      check("cont frame", nrx, 2);
      bus(1, ADDR_CTRL1, 8'h05);
      bus(0, ADDR_RXBUF, 0);
    end
    $display("test frame done");
  endtask : frame
  // Timeout and clock pin bookkeeping, sampled where outputs are settled
  always @(negedge clk) begin
    if (ck_oe === 1'b1 && ck_o !== prev_ck) begin
      if (tog > 0) gmin = (cyc - last < gmin) ? cyc - last : gmin;
      if (tog > 0) gmax = (cyc - last > gmax) ? cyc - last : gmax;
      last = cyc;
      tog++;
    end
    prev_ck = ck_o;
    if (txi === 1'b1) txat = pedges;
    if (txi === 1'b1) ntx++;
    if (rxi === 1'b1) nrx++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) err_count++;
    if (cyc == 60000) test_done();
  end
  initial begin
    {rst, rd, wr, go, ext, pol, msb, unread, prev_ck} = 9'h100;
    {adr, wdat, half, pbyte} = '0;
    {seed, err_count, checked, cyc} = {32'd8, 96'd0};
    clr();
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1, 3'h3, 8'hff);
    for (int i = 0; i < 6; i++) begin
      bus(0, ra[i], 0);
      check("reset value", got, rv[i]);
    end
    $display("test registers done");
    bus(1, ADDR_CTRL0, 8'h20);
    bus(1, ADDR_MODE, MODE_CLOCKSYNC);
    clr();
    bus(1, ADDR_TXBUF, 8'h5a);
    repeat (60) @(posedge clk);
    check("no start", tog, 0);
    check("open drain", sdo_oe, 1'b0);
    check("clock on", ck_oe, 1'b1);
    bus(0, ADDR_CTRL1, 0);
    check("tx pending", got[TX_EMPTY_BIT], 1'b0);
    bus(1, ADDR_MODE, MODE_DISABLED);
    repeat (2) @(negedge clk);
    check("clock off", ck_oe, 1'b0);
    bus(1, ADDR_MODE, MODE_CLOCKSYNC);
    bus(1, ADDR_CTRL1, 8'h01);
    repeat (60) @(posedge clk);
    bus(0, ADDR_CTRL1, 0);
    check("tx flushed", got[TX_EMPTY_BIT], 1'b1);
    check("no frame", tog, 0);
    $display("test start rules done");
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      frame(i > 5, rnd[0], rnd[1], rnd[2], i != 4, 0, 1, i[1:0], i[1:0] == 0 ? 8'd3 : 8'd1);
    end
    frame(0, 0, 0, 0, 1, 0, 0, 2'd0, 8'd3);
    frame(0, 1, 1, 0, 1, 0, 1, 2'd0, 8'd4);
    bus(1, ADDR_CTRL1, 8'h01);
    bus(0, ADDR_RXBUF, 0);
    check("overrun clear", got[OVERRUN_BIT], 1'b0);
    bus(1, ADDR_MODE, MODE_DISABLED);
    bus(1, ADDR_MODE, MODE_CLOCKSYNC);
    unread = 1'b0;
    frame(0, 0, 1, 1, 1, 1, 1, 2'd1, 8'd0);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
